/* File: src/bcwd_pkg.sv */
// bcwd_pkg: constants, field positions and carrier types for the boot config word decoder
// assumes: a single 10 MHz system clock; register offsets are byte addresses on Avalon-MM
`default_nettype none
package bcwd_pkg;
    // register byte offsets
    localparam logic [3:0] BCWD_OFS_WORD       = 4'h0; // programmed config word, read only
    localparam logic [3:0] BCWD_OFS_SYSCFG     = 4'h4; // runtime system config register
    localparam logic [3:0] BCWD_OFS_CTRL       = 4'h8; // cpu state inputs: debug mode, group
    localparam logic [3:0] BCWD_OFS_STATUS     = 4'hC; // decoded read-only status
    // config word field positions
    localparam int BCWD_POS_RSV_ZERO  = 31;
    localparam int BCWD_POS_DBG_FULL  = 30;
    localparam int BCWD_POS_PERM_HI   = 14;
    localparam int BCWD_POS_PERM_LO   = 12;
    localparam int BCWD_POS_FLASH_SLEEP_POWERDOWN    = 10;
    localparam int BCWD_POS_ECC_HI    = 9;
    localparam int BCWD_POS_ECC_LO    = 8;
    localparam int BCWD_POS_ISA       = 6;
    localparam int BCWD_POS_TRACE     = 5;
    localparam int BCWD_POS_TPORT     = 3;
    // system config register field positions
    localparam int BCWD_SYS_ECC_HI    = 5;
    localparam int BCWD_SYS_ECC_LO    = 4;
    localparam int BCWD_SYS_TPORT     = 3;
    // correction configuration encodings
    localparam logic [1:0] BCWD_ECC_OFF_OPEN   = 2'h3;
    localparam logic [1:0] BCWD_ECC_OFF_LOCKED = 2'h2;
    localparam logic [1:0] BCWD_ECC_DYNAMIC    = 2'h1;
    localparam logic [1:0] BCWD_ECC_FULL       = 2'h0;
    // instruction set select codes and the debug fallback group
    localparam logic [1:0] BCWD_ISA_STD        = 2'h2;
    localparam logic [1:0] BCWD_ISA_COMPRESSED = 2'h3;
    localparam logic [1:0] BCWD_GROUP_FALLBACK = 2'h3;
    // reset values
    localparam logic [31:0] BCWD_RST_WORD      = 32'h00000000;
    localparam logic [31:0] BCWD_RST_ZERO      = 32'h00000000;

    typedef enum logic [1:0] {
        BCWD_ST_RESET   = 2'b00,
        BCWD_ST_CAPTURE = 2'b01,
        BCWD_ST_RUN     = 2'b10,
        BCWD_ST_FILL    = 2'b11
    } bcwd_state_t;

    // decoded settings that travel together
    typedef struct packed {
        logic       debug_full;
        logic [2:0] permit;
        logic       flash_sleep_powerdown;
        logic [1:0] ecc_cfg;
        logic       ecc_locked;
        logic       ecc_enabled;
        logic       ecc_dynamic;
        logic       word_write_block;
        logic [1:0] isa_sel;
        logic       exc_isa_flag;
        logic       trace_en;
        logic       test_port_en;
    } bcwd_cfg_t;
endpackage : bcwd_pkg
`default_nettype wire

/* File: src/bcwd_field_decode.sv */
// bcwd_field_decode: pure decode of a config word into settings
// assumes: the word is stable while it is read; output is combinational
`default_nettype none
module bcwd_field_decode
    import bcwd_pkg::*;
(
    // word in
    input  wire logic [31:0] i_word,
    // decoded settings out
    output var bcwd_cfg_t    o_cfg
);
    logic [1:0] ecc;
    assign ecc = i_word[BCWD_POS_ECC_HI:BCWD_POS_ECC_LO];

    // field decode, one term per setting
    always_comb begin
        o_cfg                       = '0;
        o_cfg.debug_full            = i_word[BCWD_POS_DBG_FULL];
        o_cfg.permit                = i_word[BCWD_POS_PERM_HI:BCWD_POS_PERM_LO];
        o_cfg.flash_sleep_powerdown = i_word[BCWD_POS_FLASH_SLEEP_POWERDOWN];
        o_cfg.ecc_cfg               = ecc;
        o_cfg.ecc_locked            = (ecc != BCWD_ECC_OFF_OPEN);
        o_cfg.ecc_enabled           = (ecc == BCWD_ECC_DYNAMIC) || (ecc == BCWD_ECC_FULL);
        o_cfg.ecc_dynamic           = (ecc == BCWD_ECC_DYNAMIC);
        o_cfg.word_write_block      = (ecc == BCWD_ECC_FULL);
        o_cfg.isa_sel               = i_word[BCWD_POS_ISA] ? BCWD_ISA_STD
                                                           : BCWD_ISA_COMPRESSED;
        o_cfg.exc_isa_flag          = ~i_word[BCWD_POS_ISA];
        o_cfg.trace_en              = i_word[BCWD_POS_TRACE];
        o_cfg.test_port_en          = i_word[BCWD_POS_TPORT];
    end
endmodule : bcwd_field_decode
`default_nettype wire

/* File: src/bcwd_perm_map.sv */
// bcwd_perm_map: maps the cpu permission group in debug mode to the granted group
// assumes: inputs come from registers on the same clock
`default_nettype none
module bcwd_perm_map
    import bcwd_pkg::*;
(
    // request
    input  wire logic       i_debug_mode,
    input  wire logic [1:0] i_group,
    input  wire logic [2:0] i_permit,
    // result
    output logic      [1:0] o_group
);
    logic denied;

    // group 3 is never in the permit field, so it simply passes through
    always_comb begin
        denied = 1'b0;
        if (i_group != BCWD_GROUP_FALLBACK) begin
            denied = ~i_permit[i_group];
        end
        o_group = (i_debug_mode && denied) ? BCWD_GROUP_FALLBACK : i_group;
    end
endmodule : bcwd_perm_map
`default_nettype wire

/* File: src/bcwd_top.sv */
// bcwd_top: boot configuration word decoder with an Avalon-MM register slave
// assumes: i_cfg_word comes from nonvolatile storage outside the clock domain and is
// stable around reset release; cpu state inputs come from logic on i_clk
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`default_nettype none
// Contract
// - bit 30 picks full or reduced debug
// - bits 14-12 permit debug groups two..zero
// - denied group in debug gets group 3
// - bit 10 powers flash down in sleep
// - reset copies bits 9-8 into runtime field
// - decode correction modes, lock, word-write block
// - bit 6 selects boot isa and flag
// - bit 5 enables cpu trace
// - test-port bit loads system config bit
module bcwd_top
    import bcwd_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // nonvolatile word
    input  wire logic [31:0] i_cfg_word,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // power state
    input  wire logic        i_sleep,
    input  wire logic        i_regulator_standby_ctl,
    output logic             o_flash_powerdown,
    // cpu facing settings
    output logic             o_debug_port_boot_full,
    output logic      [1:0]  o_boot_isa_select,
    output logic             o_exception_isa_flag,
    output logic             o_trace_enable_bit,
    output logic             o_test_port_enable,
    output logic      [1:0]  o_runtime_correction_ctl,
    output logic             o_ecc_enabled,
    output logic             o_ecc_dynamic,
    output logic             o_word_write_block,
    output logic      [1:0]  o_granted_group
);
    // word synchroniser: first stage feeds only the second
    logic [31:0] sync1_r, sync1_nxt;
    logic [31:0] sync2_r, sync2_nxt;
    // captured word and control
    logic [31:0] word_r, word_nxt;
    bcwd_state_t state_r, state_nxt;
    bcwd_cfg_t   cfg_r, cfg_nxt;
    bcwd_cfg_t   dec;
    // runtime registers
    logic [1:0]  ecc_ctl_r, ecc_ctl_nxt;
    logic        tport_r, tport_nxt;
    logic        dbg_mode_r, dbg_mode_nxt;
    logic [1:0]  group_r, group_nxt;
    // bus
    logic        ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        req;
    logic        run;

    always_comb begin
        sync1_nxt = i_cfg_word;
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_r <= BCWD_RST_ZERO;
            sync2_r <= BCWD_RST_ZERO;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    bcwd_field_decode u_decode (
        .i_word (sync2_r),
        .o_cfg  (dec)
    );

    // capture sequence: two cycles to fill the synchroniser, then one capture
    always_comb begin
        state_nxt   = state_r;
        word_nxt    = word_r;
        cfg_nxt     = cfg_r;
        ecc_ctl_nxt = ecc_ctl_r;
        tport_nxt   = tport_r;
        case (state_r)
            BCWD_ST_RESET: begin
                state_nxt = BCWD_ST_FILL;
            end
            BCWD_ST_FILL: begin
                state_nxt = BCWD_ST_CAPTURE;      // synchroniser leaves reset empty, wait once more
            end
            BCWD_ST_CAPTURE: begin
                word_nxt    = sync2_r;
                cfg_nxt     = dec;
                ecc_ctl_nxt = dec.ecc_cfg;
                tport_nxt   = dec.test_port_en;
                state_nxt   = BCWD_ST_RUN;
            end
            BCWD_ST_RUN: begin
                state_nxt = BCWD_ST_RUN;          // settings frozen until next reset
                // runtime field only writable when the word left it open
                if (ack_nxt && i_avs_write && i_avs_address == BCWD_OFS_SYSCFG
                    && i_avs_byteenable[0]) begin
                    if (!cfg_r.ecc_locked) begin
                        ecc_ctl_nxt = i_avs_writedata[BCWD_SYS_ECC_HI:BCWD_SYS_ECC_LO];
                    end
                    tport_nxt = i_avs_writedata[BCWD_SYS_TPORT];
                end
            end
            default: begin
                state_nxt = BCWD_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r   <= BCWD_ST_RESET;
            word_r    <= BCWD_RST_WORD;
            cfg_r     <= '0;
            ecc_ctl_r <= 2'h0;
            tport_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            word_r    <= word_nxt;
            cfg_r     <= cfg_nxt;
            ecc_ctl_r <= ecc_ctl_nxt;
            tport_r   <= tport_nxt;
        end
    end

    // bus slave: one wait cycle, then ack; requests held off until capture is done
    assign run = (state_r == BCWD_ST_RUN);
    assign req = (i_avs_read ^ i_avs_write) && run;

    always_comb begin
        ack_nxt      = req && !ack_r;
        rdata_nxt    = rdata_r;
        dbg_mode_nxt = dbg_mode_r;
        group_nxt    = group_r;
        if (ack_nxt && i_avs_read) begin
            case (i_avs_address)
                BCWD_OFS_WORD:   rdata_nxt = word_r;   // programmed value
                BCWD_OFS_SYSCFG: rdata_nxt = {26'h0, ecc_ctl_r, tport_r, 3'h0};
                BCWD_OFS_CTRL:   rdata_nxt = {29'h0, group_r, dbg_mode_r};
                BCWD_OFS_STATUS: rdata_nxt = {24'h0, cfg_r.word_write_block,
                                              cfg_r.ecc_dynamic, cfg_r.ecc_enabled,
                                              cfg_r.ecc_locked, 2'h0, o_granted_group};
                default:         rdata_nxt = 32'h00000000; // unmapped reads as zero
            endcase
        end
        if (ack_nxt && i_avs_write && i_avs_address == BCWD_OFS_CTRL
            && i_avs_byteenable[0]) begin
            dbg_mode_nxt = i_avs_writedata[0];
            group_nxt    = i_avs_writedata[2:1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_r      <= 1'b0;
            rdata_r    <= 32'h00000000;
            dbg_mode_r <= 1'b0;
            group_r    <= 2'h0;
        end else begin
            ack_r      <= ack_nxt;
            rdata_r    <= rdata_nxt;
            dbg_mode_r <= dbg_mode_nxt;
            group_r    <= group_nxt;
        end
    end

    assign o_avs_waitrequest = !ack_r;
    assign o_avs_readdata    = rdata_r;

    bcwd_perm_map u_perm (
        .i_debug_mode (dbg_mode_r),
        .i_group      (group_r),
        .i_permit     (cfg_r.permit),
        .o_group      (o_granted_group)
    );

    // flash power-down: word bit forces it in sleep, else regulator control decides
    assign o_flash_powerdown = i_sleep && (cfg_r.flash_sleep_powerdown
                                           || i_regulator_standby_ctl);

    assign o_debug_port_boot_full   = cfg_r.debug_full;
    assign o_boot_isa_select        = cfg_r.isa_sel;
    assign o_exception_isa_flag     = cfg_r.exc_isa_flag;
    assign o_trace_enable_bit       = cfg_r.trace_en;
    assign o_test_port_enable       = tport_r;
    assign o_runtime_correction_ctl = ecc_ctl_r;
    assign o_ecc_enabled            = cfg_r.ecc_enabled;
    assign o_ecc_dynamic            = cfg_r.ecc_dynamic;
    assign o_word_write_block       = cfg_r.word_write_block;

    // assertions
    property p_dbg_full;
        @(posedge i_clk) disable iff (!i_rst_b)
        run |-> o_debug_port_boot_full == word_r[BCWD_POS_DBG_FULL];
    endproperty
    a_dbg_full: assert property (p_dbg_full) else $error("debug mode bit mismatch");

    property p_permit;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && group_r != 2'h3 && word_r[BCWD_POS_PERM_LO + group_r])
            |-> o_granted_group == group_r;
    endproperty
    a_permit: assert property (p_permit) else $error("permitted group altered");

    property p_fallback;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && dbg_mode_r && group_r != 2'h3 && !word_r[BCWD_POS_PERM_LO + group_r])
            |-> o_granted_group == 2'h3;
    endproperty
    a_fallback: assert property (p_fallback) else $error("denied group not demoted");

    property p_flash_sleep_powerdown;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && i_sleep && word_r[BCWD_POS_FLASH_SLEEP_POWERDOWN]) |-> o_flash_powerdown;
    endproperty
    a_flash_sleep_powerdown: assert property (p_flash_sleep_powerdown) else $error("flash not powered down");

    property p_ecc_copy;
        @(posedge i_clk) disable iff (!i_rst_b)
        (state_r == BCWD_ST_CAPTURE) |=> o_runtime_correction_ctl == word_r[9:8];
    endproperty
    a_ecc_copy: assert property (p_ecc_copy) else $error("ecc field not copied");

    property p_ecc_lock;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && word_r[9:8] != 2'h3) |=> $stable(o_runtime_correction_ctl);
    endproperty
    a_ecc_lock: assert property (p_ecc_lock) else $error("locked ecc field changed");

    property p_isa;
        @(posedge i_clk) disable iff (!i_rst_b)
        run |-> (o_boot_isa_select == (word_r[BCWD_POS_ISA] ? 2'h2 : 2'h3))
                && (o_exception_isa_flag == !word_r[BCWD_POS_ISA]);
    endproperty
    a_isa: assert property (p_isa) else $error("isa select wrong");

    property p_trace;
        @(posedge i_clk) disable iff (!i_rst_b)
        run |-> o_trace_enable_bit == word_r[BCWD_POS_TRACE];
    endproperty
    a_trace: assert property (p_trace) else $error("trace enable wrong");

    property p_tport;
        @(posedge i_clk) disable iff (!i_rst_b)
        (state_r == BCWD_ST_CAPTURE) |=> o_test_port_enable == word_r[BCWD_POS_TPORT];
    endproperty
    a_tport: assert property (p_tport) else $error("test port not loaded");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        run |=> $stable(word_r) && $stable(cfg_r);
    endproperty
    a_hold: assert property (p_hold) else $error("captured word changed");

    // mode flags must follow the captured correction field in every mode
    property p_ecc_flags;
        @(posedge i_clk) disable iff (!i_rst_b)
        run |-> (o_ecc_enabled == !word_r[BCWD_POS_ECC_HI])
                && (o_ecc_dynamic == (word_r[9:8] == 2'h1))
                && (o_word_write_block == (word_r[9:8] == 2'h0));
    endproperty
    a_ecc_flags: assert property (p_ecc_flags) else $error("ecc mode flags wrong");

    // an open field must really take a software write
    property p_ecc_open;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && ack_nxt && i_avs_write && i_avs_address == BCWD_OFS_SYSCFG
            && i_avs_byteenable[0] && word_r[9:8] == 2'h3)
            |=> o_runtime_correction_ctl == $past(i_avs_writedata[5:4]);
    endproperty
    a_ecc_open: assert property (p_ecc_open) else $error("open ecc field not written");

    property p_word_read;
        @(posedge i_clk) disable iff (!i_rst_b)
        (ack_nxt && i_avs_read && i_avs_address == BCWD_OFS_WORD)
            |=> o_avs_readdata == word_r;
    endproperty
    a_word_read: assert property (p_word_read) else $error("word read wrong");

    property p_no_debug;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && !dbg_mode_r) |-> o_granted_group == group_r;
    endproperty
    a_no_debug: assert property (p_no_debug) else $error("group changed outside debug");

    property p_flash_sleep_powerdown_reg;
        @(posedge i_clk) disable iff (!i_rst_b)
        (run && !word_r[BCWD_POS_FLASH_SLEEP_POWERDOWN])
            |-> o_flash_powerdown == (i_sleep && i_regulator_standby_ctl);
    endproperty
    a_flash_sleep_powerdown_reg: assert property (p_flash_sleep_powerdown_reg) else $error("regulator path wrong");
endmodule : bcwd_top
`default_nettype wire

/* File: verification/tb_top.sv */
// tb_top: self-checking bench for the boot config word decoder
// assumes: bcwd_pkg and the src/ design compiled first; avalon master lives in bus()
`default_nettype none
module tb_top
    import bcwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
    } bcwd_tb_note_t;

    logic        i_clk                   = 1'b0;
    logic        i_rst_b                 = 1'b0;
    logic [31:0] i_cfg_word              = 32'h7FFFFFFF;
    logic [3:0]  i_avs_address           = 4'h0;
    logic        i_avs_read              = 1'b0;
    logic        i_avs_write             = 1'b0;
    logic [31:0] i_avs_writedata         = 32'h00000000;
    logic [3:0]  i_avs_byteenable        = 4'hF;
    logic        i_sleep                 = 1'b0;
    logic        i_regulator_standby_ctl = 1'b0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic        o_flash_powerdown;
    logic        o_debug_port_boot_full;
    logic [1:0]  o_boot_isa_select;
    logic        o_exception_isa_flag;
    logic        o_trace_enable_bit;
    logic        o_test_port_enable;
    logic [1:0]  o_runtime_correction_ctl;
    logic        o_ecc_enabled;
    logic        o_ecc_dynamic;
    logic        o_word_write_block;
    logic [1:0]  o_granted_group;
    int          n_errors    = 0;
    int          comparisons = 0;
    bcwd_tb_note_t notes[$];
    bcwd_tb_note_t nt;

    bcwd_top u_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_word(i_cfg_word),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_sleep(i_sleep), .i_regulator_standby_ctl(i_regulator_standby_ctl),
        .o_flash_powerdown(o_flash_powerdown), .o_debug_port_boot_full(o_debug_port_boot_full),
        .o_boot_isa_select(o_boot_isa_select), .o_exception_isa_flag(o_exception_isa_flag),
        .o_trace_enable_bit(o_trace_enable_bit), .o_test_port_enable(o_test_port_enable),
        .o_runtime_correction_ctl(o_runtime_correction_ctl), .o_ecc_enabled(o_ecc_enabled),
        .o_ecc_dynamic(o_ecc_dynamic), .o_word_write_block(o_word_write_block),
        .o_granted_group(o_granted_group)
    );

    // 10 MHz system clock
    always #50 i_clk = ~i_clk;

    task automatic fail(input string what);
        n_errors++;
        $display("unexpected at %0t: %s", $time, what);
    endtask : fail

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // one avalon access; the request is held until the rising edge at which
    // waitrequest is sampled low, and released right after that same edge
    task automatic bus(input logic is_rd, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address    <= a;
        i_avs_read       <= is_rd;
        i_avs_write      <= !is_rd;
        i_avs_writedata  <= is_rd ? $urandom() : wd;
        i_avs_byteenable <= be;
        @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0 && n < 40) begin
            n++;
            @(posedge i_clk);
        end
        if (n >= 40)
            fail("bus access never answered");
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b0, a, d, be);
    endtask : wr

    // the expected value goes in the queue before the access starts
    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        notes.push_back('{d: d & m, m: m});
        bus(1'b1, a, 32'h00000000, 4'hF);
    endtask : rd

    // monitor: compare read data in the cycle it stands against the oldest note
    always @(negedge i_clk) begin
        if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
            if (notes.size() == 0)
                fail("read data with no note");
            else begin
                // pop first: argument order must not decide which note is used
                nt = notes.pop_front();
                chk(o_avs_readdata & nt.m, nt.d, "read data");
            end
        end
    end

    // reset with a new word; the word settles well before release
    task automatic boot(input logic [31:0] w);
        @(posedge i_clk);
        i_rst_b    <= 1'b0;
        i_cfg_word <= w;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
    endtask : boot

    function automatic logic [1:0] grant(input logic dbg, input logic [1:0] g,
                                         input logic [2:0] p);
        return (dbg && g != 2'h3 && !p[g]) ? BCWD_GROUP_FALLBACK : g;
    endfunction : grant

    // captured settings other than the permit field and flash power-down bit checked together against the word
    task automatic chk_out(input logic [31:0] w);
        logic [1:0] e;
        e = w[9:8];
        chk({21'h0, o_debug_port_boot_full, o_boot_isa_select, o_exception_isa_flag,
             o_trace_enable_bit, o_test_port_enable, o_runtime_correction_ctl,
             o_ecc_enabled, o_ecc_dynamic, o_word_write_block},
            {21'h0, w[30], w[6] ? BCWD_ISA_STD : BCWD_ISA_COMPRESSED, !w[6], w[5], w[3],
             e, !e[1], e == 2'h1, e == 2'h0}, "decoded settings");
    endtask : chk_out

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        fail("watchdog expired");
        wrap_up();
    end

    initial begin
        logic [31:0] w;
        logic [1:0]  e;
        logic [1:0]  g;
        void'($urandom(32'hEB71));
        for (int k = 0; k < 12; k++) begin
            w        = $urandom();
            w[31]    = 1'b0;
            w[29:15] = 15'h7FFF;
            w[11]    = 1'b1;
            w[7]     = 1'b1;
            if (k < 8) begin
                w[9:8] = k[1:0];
                w[6]   = k[2];
            end
            e = w[9:8];
            boot(w);
            // first access stalls until capture is done
            rd(BCWD_OFS_WORD, w, 32'hFFFFFFFF);
            chk_out(w);
            rd(BCWD_OFS_SYSCFG, {26'h0, e, w[3], 3'h0}, 32'h38);
            rd(BCWD_OFS_STATUS, {24'h0, e == 2'h0, e == 2'h1, !e[1], e != 2'h3, 4'h0},
               32'hF0);
            // every debug mode and group combination, back to back
            for (int j = 0; j < 8; j++) begin
                wr(BCWD_OFS_CTRL, {29'h0, j[1:0], j[2]}, 4'h1);
                g = grant(j[2], j[1:0], w[14:12]);
                rd(BCWD_OFS_STATUS, {30'h0, g}, 32'h3);
                chk({30'h0, o_granted_group}, {30'h0, g}, "granted group");
            end
            // lane 0 disabled: control must keep its last value
            wr(BCWD_OFS_CTRL, 32'h00000000, 4'hE);
            rd(BCWD_OFS_CTRL, 32'h00000007, 32'h7);
            for (int j = 0; j < 4; j++) begin
                @(posedge i_clk);
                i_sleep                 <= j[0];
                i_regulator_standby_ctl <= j[1];
                @(negedge i_clk);
                chk({31'h0, o_flash_powerdown}, {31'h0, j[0] & (w[10] | j[1])},
                    "flash powerdown");
            end
            // word changes after capture and a write to it: nothing may move
            wr(BCWD_OFS_WORD, ~w, 4'hF);
            @(posedge i_clk);
            i_cfg_word <= ~w;
            repeat (4) @(posedge i_clk);
            rd(BCWD_OFS_WORD, w, 32'hFFFFFFFF);
            chk_out(w);
            rd(4'h2, 32'h00000000, 32'hFFFFFFFF);
            // runtime correction field only writable when the word left it open
            wr(BCWD_OFS_SYSCFG, {26'h0, ~e, ~w[3], 3'h0}, 4'hF);
            rd(BCWD_OFS_SYSCFG, {26'h0, (e == BCWD_ECC_OFF_OPEN) ? ~e : e, ~w[3], 3'h0},
               32'h38);
        end
        repeat (2) @(posedge i_clk);
        if (notes.size() != 0)
            fail("reads left unanswered");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
